// File: common/tlk_defines.svh
// Offsets, field positions, reset values and codes of the lockout block
`ifndef TLK_DEFINES_SVH
`define TLK_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TLK_OFS_CTRL      8'h00
`define TLK_OFS_STATUS    8'h04
`define TLK_OFS_LOCK_RST  8'h08
`define TLK_OFS_CNT_CLR   8'h0C
`define TLK_OFS_CNT0      8'h10
`define TLK_OFS_CNT1      8'h14
`define TLK_OFS_CNT2      8'h18
`define TLK_OFS_CNT3      8'h1C
`define TLK_OFS_SHOTS     8'h20

// ----------------------------------------
// Fields, codes and reset values
// ----------------------------------------
`define TLK_BIT_EN        0
`define TLK_BIT_RST_REQ   0
`define TLK_CLR_TRIPS     32'h0000_0001
`define TLK_CLR_SHOTS     32'h0000_0002
`define TLK_CTRL_RST      1'b0
`define TLK_CNT_MAX       16'hFFFF
`define TLK_CNT_ONE       16'h0001
`define TLK_CNT_ZERO      16'h0000
`define TLK_ZERO32        32'h0000_0000

`endif

// File: common/tlk_pkg.sv
// Types shared by the lockout and trip counter block
package tlk_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int TLK_CW = 16;
  localparam int TLK_NCNT = 4;

  typedef logic [TLK_NCNT-1:0][TLK_CW-1:0] tlk_cnt_t;
  typedef logic [1:0] tlk_idx_t;

  // ----------------------------------------
  // Control states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_W1   = 4'b0001,
    ST_W2   = 4'b0010,
    ST_LOAD = 4'b0100,
    ST_RUN  = 4'b1000
  } tlk_state_e;

  typedef struct packed {
    tlk_state_e st;
    logic ext_s1;
    logic ext_s2;
    logic dir_s1;
    logic dir_s2;
    logic bat_s1;
    logic bat_s2;
    logic lock_en;
    logic latch;
    logic contact;
    logic seq_act;
    tlk_idx_t first;
    logic [TLK_CW-1:0] shots;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic nv_wr;
    logic cnt_inc;
    tlk_idx_t cnt_sel;
    logic cnt_clr;
  } tlk_top_s;

  typedef struct packed {
    tlk_cnt_t cnt;
  } tlk_bank_s;

endpackage : tlk_pkg

// File: design/tlk_cnt_bank.sv
// Non-volatile trip counter bank: load, increment with wrap, clear
`include "tlk_defines.svh"

module tlk_cnt_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire tlk_pkg::tlk_cnt_t load_data,
  input wire logic inc,
  input wire tlk_pkg::tlk_idx_t inc_sel,
  input wire logic clr,
  // Counts
  output tlk_pkg::tlk_cnt_t counts
);
  import tlk_pkg::*;

  tlk_bank_s s_reg;
  tlk_bank_s s_next;

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.cnt = load_data;
    end
    if (clr) begin
      s_next.cnt = '0;
    end
    if (inc) begin
      // Plain add wraps from max to zero
      s_next.cnt[inc_sel] = s_next.cnt[inc_sel] + `TLK_CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign counts = s_reg.cnt;

  chk_inc_by_one: assert property (@(posedge clk) disable iff (rst)
    inc && !clr && !load |=>
      s_reg.cnt[$past(inc_sel)] == $past(s_reg.cnt[inc_sel]) + `TLK_CNT_ONE)
    else $error("counter did not rise by one");

  chk_wrap_zero: assert property (@(posedge clk) disable iff (rst)
    inc && !clr && !load && s_reg.cnt[inc_sel] == `TLK_CNT_MAX |=>
      s_reg.cnt[$past(inc_sel)] == `TLK_CNT_ZERO)
    else $error("counter did not wrap to zero");

endmodule : tlk_cnt_bank

// File: design/tlk_top.sv
// Trip lockout latch, lockout contact drive and trip counters over APB
`include "tlk_defines.svh"

// Function
// - Lockout enabled and no trip: lockout contact driven closed.
// - Any routed signal opens the contact, which then latches open.
// - External lockout digital input also sets the lockout latch.
// - Reset from input, panel or parameter; ignored while source active.
// - With charged battery, lockout state is restored after power returns.
// - Without battery, lockout comes up set with contact open.
// - The first stage trip of a fault sequence raises its counter by exactly one; the non-overcurrent stages share counter 3.
// - Four counters: three overcurrent stages, one shared for the rest.
// - Counter values kept in non-volatile storage across power loss.
// - Counters readable by panel and parameters, clearable by a parameter.
// - A counter at maximum wraps to zero on next increment.
// - Within one fault sequence only the first tripping stage counts.
// - Clear code 1 erases trip counts, code 2 erases reclose shots.
// - Master reset leaves the non-volatile trip counters unchanged.
module tlk_top #(
  parameter int NOTHER = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Protection stages, same clock
  input wire logic [2:0] trip_ovc,
  input wire logic [NOTHER-1:0] trip_other,
  input wire logic routed_lockout,
  input wire logic panel_reset,
  input wire logic master_reset,
  input wire logic ar_shot,
  // Digital inputs and battery pin
  input wire logic ext_lockout_in,
  input wire logic di_reset_in,
  input wire logic battery_ok_in,
  // Battery backed and non-volatile store
  input wire logic nv_lock_restore,
  input wire tlk_pkg::tlk_cnt_t nv_cnt_restore,
  output tlk_pkg::tlk_cnt_t nv_cnt_save,
  output logic nv_cnt_wr,
  output logic nv_lock_save,
  // Lockout output contact
  output logic lockout_power_output
);
  import tlk_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic tlk_idx_t first_idx(input logic [3:0] v);
    tlk_idx_t r;
    r = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        r = i[1:0];
      end
    end
    return r;
  endfunction : first_idx

  function automatic logic [31:0] cnt_word(input tlk_cnt_t c,
                                           input tlk_idx_t i);
    logic [31:0] w;
    w = `TLK_ZERO32;
    w[TLK_CW-1:0] = c[i];
    return w;
  endfunction : cnt_word

  tlk_top_s s_reg;
  tlk_top_s s_next;
  tlk_cnt_t counts;
  logic [3:0] trips;
  logic src_act;
  logic rst_req;
  logic wr_acc;
  logic setup;
  logic run;

  assign trips = {|trip_other, trip_ovc};
  assign src_act = routed_lockout | s_reg.ext_s2;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && s_reg.pready && pwrite;
  assign run = s_reg.st == ST_RUN;
  assign rst_req = panel_reset || s_reg.dir_s2 ||
    (wr_acc && paddr == `TLK_OFS_LOCK_RST && pwdata[`TLK_BIT_RST_REQ]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ext_s1 = ext_lockout_in;
    s_next.ext_s2 = s_reg.ext_s1;
    s_next.dir_s1 = di_reset_in;
    s_next.dir_s2 = s_reg.dir_s1;
    s_next.bat_s1 = battery_ok_in;
    s_next.bat_s2 = s_reg.bat_s1;
    s_next.cnt_inc = 1'b0;
    s_next.cnt_clr = 1'b0;
    s_next.nv_wr = s_reg.cnt_inc || s_reg.cnt_clr;
    case (s_reg.st)
      ST_W1: begin
        s_next.st = ST_W2;
      end
      ST_W2: begin
        s_next.st = ST_LOAD;
      end
      ST_LOAD: begin
        // Battery decides between restore and forced lockout
        if (s_reg.bat_s2) begin
          s_next.latch = nv_lock_restore;
        end else begin
          s_next.latch = 1'b1;
        end
        s_next.st = ST_RUN;
      end
      ST_RUN: begin
        // Clear loses against a set in the same cycle
        if (rst_req && !src_act) begin
          s_next.latch = 1'b0;
        end
        if (s_reg.lock_en && src_act) begin
          s_next.latch = 1'b1;
        end
        if (|trips && !s_reg.seq_act) begin
          s_next.seq_act = 1'b1;
          s_next.first = first_idx(trips);
          s_next.cnt_inc = 1'b1;
          s_next.cnt_sel = first_idx(trips);
        end
        if (!(|trips)) begin
          s_next.seq_act = 1'b0;
        end
      end
      default: begin
        s_next.st = ST_W1;
      end
    endcase
    // Master reset clears the memorized first stage only
    if (master_reset) begin
      s_next.first = 2'd0;
    end
    if (ar_shot) begin
      s_next.shots = s_reg.shots + `TLK_CNT_ONE;
    end
    s_next.contact = run && s_reg.lock_en && !s_next.latch;
    // APB: answer in the access cycle after setup
    s_next.pready = setup;
    if (setup) begin
      s_next.pslverr = 1'b0;
      s_next.prdata = `TLK_ZERO32;
      case (paddr)
        `TLK_OFS_CTRL: begin
          s_next.prdata[`TLK_BIT_EN] = s_reg.lock_en;
        end
        `TLK_OFS_STATUS: begin
          s_next.prdata[5:0] = {s_reg.first, s_reg.seq_act,
                                s_reg.bat_s2, s_reg.contact, s_reg.latch};
        end
        `TLK_OFS_LOCK_RST: begin
        end
        `TLK_OFS_CNT_CLR: begin
        end
        `TLK_OFS_CNT0: begin
          s_next.prdata = cnt_word(counts, 2'd0);
        end
        `TLK_OFS_CNT1: begin
          s_next.prdata = cnt_word(counts, 2'd1);
        end
        `TLK_OFS_CNT2: begin
          s_next.prdata = cnt_word(counts, 2'd2);
        end
        `TLK_OFS_CNT3: begin
          s_next.prdata = cnt_word(counts, 2'd3);
        end
        `TLK_OFS_SHOTS: begin
          s_next.prdata[TLK_CW-1:0] = s_reg.shots;
        end
        default: begin
          s_next.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_acc && paddr == `TLK_OFS_CTRL) begin
      s_next.lock_en = pwdata[`TLK_BIT_EN];
    end
    if (wr_acc && paddr == `TLK_OFS_CNT_CLR) begin
      if (pwdata == `TLK_CLR_TRIPS) begin
        s_next.cnt_clr = 1'b1;
      end
      if (pwdata == `TLK_CLR_SHOTS) begin
        // A shot in the clearing cycle still counts
        s_next.shots = ar_shot ? `TLK_CNT_ONE : `TLK_CNT_ZERO;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_W1;
      s_reg.lock_en <= `TLK_CTRL_RST;
      s_reg.latch <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Counter bank
  // ----------------------------------------
  tlk_cnt_bank u_bank (
    .clk(clk),
    .rst(rst),
    .load(s_reg.st == ST_LOAD),
    .load_data(nv_cnt_restore),
    .inc(s_reg.cnt_inc),
    .inc_sel(s_reg.cnt_sel),
    .clr(s_reg.cnt_clr),
    .counts(counts)
  );

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign nv_cnt_save = counts;
  assign nv_cnt_wr = s_reg.nv_wr;
  assign nv_lock_save = s_reg.latch;
  assign lockout_power_output = s_reg.contact;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_contact_opens: assert property (@(posedge clk) disable iff (rst)
    run && s_reg.lock_en && routed_lockout |=> !lockout_power_output
      && s_reg.latch)
    else $error("routed signal did not open and latch");

  chk_contact_closed: assert property (@(posedge clk) disable iff (rst)
    run && s_reg.lock_en && !s_reg.latch && !src_act |=>
      lockout_power_output)
    else $error("contact not closed without trip");

  chk_ext_sets: assert property (@(posedge clk) disable iff (rst)
    run && s_reg.lock_en && s_reg.ext_s2 |=> s_reg.latch)
    else $error("external input did not set lockout");

  chk_reset_held: assert property (@(posedge clk) disable iff (rst)
    run && s_reg.latch && src_act |=> s_reg.latch)
    else $error("reset accepted while source active");

  chk_reset_clears: assert property (@(posedge clk) disable iff (rst)
    run && s_reg.latch && rst_req && !src_act |=> !s_reg.latch)
    else $error("reset request did not clear lockout");

  chk_bat_restore: assert property (@(posedge clk) disable iff (rst)
    s_reg.st == ST_LOAD && s_reg.bat_s2 |=>
      s_reg.latch == $past(nv_lock_restore))
    else $error("lockout not restored with battery");

  chk_nobat_lock: assert property (@(posedge clk) disable iff (rst)
    s_reg.st == ST_LOAD && !s_reg.bat_s2 |=> s_reg.latch &&
      !lockout_power_output)
    else $error("lockout not forced without battery");

  chk_first_only: assert property (@(posedge clk) disable iff (rst)
    s_reg.seq_act && $past(s_reg.seq_act) |-> !s_reg.cnt_inc)
    else $error("second count in one fault sequence");

  chk_seq_end: assert property (@(posedge clk) disable iff (rst)
    run && s_reg.seq_act && !(|trips) |=> !s_reg.seq_act)
    else $error("sequence did not end");

  chk_clr_code: assert property (@(posedge clk) disable iff (rst)
    wr_acc && paddr == `TLK_OFS_CNT_CLR && pwdata == `TLK_CLR_TRIPS
      |=> s_reg.cnt_clr ##1 counts == '0)
    else $error("clear code did not erase counts");

  chk_master_keep: assert property (@(posedge clk) disable iff (rst)
    run && master_reset && !s_reg.cnt_inc && !s_reg.cnt_clr |=>
      $stable(counts))
    else $error("master reset changed counters");

endmodule : tlk_top

// File: tb/tlk_nv_model.sv
// Non-volatile count store and battery backed lockout latch
module tlk_nv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Store traffic
  input wire logic wr,
  input wire tlk_pkg::tlk_cnt_t save,
  input wire logic lock_save,
  input wire logic bat,
  output tlk_pkg::tlk_cnt_t restore,
  output logic lock_restore
);
  timeunit 1ns;
  timeprecision 100ps;
  import tlk_pkg::*;
  tlk_cnt_t mem = '0;
  logic lock = 1'b0;
  int run = 0;

  // ----------------------------------------
  // Latch storage frozen during power loss and init; counts written on every wr
  // ----------------------------------------
  always @(posedge clk) begin
    run <= rst ? 0 : (run < 8 ? run + 1 : run);
    if (wr) begin
      mem <= save;
    end
    if (!rst && run == 8 && bat) begin
      lock <= lock_save;
    end
  end
  assign restore = mem;
  // Without battery the restore output reads 0 while the stored latch is held
  assign lock_restore = bat ? lock : 1'b0;
endmodule : tlk_nv_model

// File: tb/testbench.sv
// Self-checking bench of the lockout and trip counter block
`include "tlk_defines.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tlk_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, rerr, nv_cnt_wr, nv_lock_save, nv_lock_restore;
  logic [2:0] trip_ovc = 3'h0;
  logic [3:0] trip_other = 4'h0;
  logic routed = 0, panel = 0, mres = 0, shot = 0, ext = 0, dirst = 0;
  logic bat = 1, contact;
  tlk_cnt_t nv_cnt_restore, nv_cnt_save;
  int failures = 0;
  int comparisons = 0;
  logic [15:0] exp_cnt [4] = '{default: 16'h0000};
  logic [2:0] t_ovc [7] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h6, 3'h0, 3'h4};
  logic [3:0] t_oth [7] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h8, 4'h2};
  int t_idx [7] = '{0, 1, 2, 3, 1, 3, 2};

  always #2.5 clk = ~clk;

  tlk_top tlk_top_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_ovc(trip_ovc), .trip_other(trip_other), .routed_lockout(routed),
    .panel_reset(panel), .master_reset(mres), .ar_shot(shot),
    .ext_lockout_in(ext), .di_reset_in(dirst), .battery_ok_in(bat),
    .nv_lock_restore(nv_lock_restore), .nv_cnt_restore(nv_cnt_restore),
    .nv_cnt_save(nv_cnt_save), .nv_cnt_wr(nv_cnt_wr),
    .nv_lock_save(nv_lock_save), .lockout_power_output(contact));

  tlk_nv_model tlk_nv_model_inst (.clk(clk), .rst(rst), .wr(nv_cnt_wr),
    .save(nv_cnt_save), .lock_save(nv_lock_save), .bat(bat),
    .restore(nv_cnt_restore), .lock_restore(nv_lock_restore));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic pin(input string nm, input logic e, input logic g);
    chk(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask : pin

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      final_report();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdat);
  endtask : rd

  task automatic counts();
    for (int i = 0; i < 4; i++) begin
      rd(`TLK_OFS_CNT0 + 8'(4 * i), {16'h0000, exp_cnt[i]}, "count");
    end
  endtask : counts

  task automatic rst_init();
    rst <= 1'b1;
    cyc(10);
    rst <= 1'b0;
    cyc(6);
  endtask : rst_init

  task automatic trip(input logic [2:0] o, input logic [3:0] t);
    trip_ovc <= o;
    trip_other <= t;
    cyc(3);
    trip_ovc <= 3'h0;
    trip_other <= 4'h0;
    cyc(3);
  endtask : trip

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_init();
    rd(`TLK_OFS_CTRL, `TLK_ZERO32, "ctrl");
    pin("contact", 1'b0, contact);
    apb(1'b1, `TLK_OFS_CTRL, 32'h0000_0001);
    cyc(2);
    pin("contact", 1'b1, contact);
    apb(1'b0, 8'h40, 32'h0000_0000);
    pin("slverr", 1'b1, rerr);
    chk("unmapped", `TLK_ZERO32, rdat);
    for (int i = 0; i < 7; i++) begin
      trip(t_ovc[i], t_oth[i]);
      exp_cnt[t_idx[i]]++;
      counts();
    end
    $display("test table done");
    trip_ovc <= 3'h1;
    cyc(2);
    trip_ovc <= 3'h5;
    cyc(2);
    trip(3'h0, 4'h0);
    exp_cnt[0]++;
    counts();
    trip_ovc <= 3'h1;
    cyc(2);
    trip_ovc <= 3'h0;
    cyc(1);
    trip(3'h4, 4'h0);
    exp_cnt[0]++;
    exp_cnt[2]++;
    counts();
    rd(`TLK_OFS_STATUS, 32'h0000_0026, "status");
    mres <= 1'b1;
    cyc(1);
    mres <= 1'b0;
    cyc(2);
    counts();
    rd(`TLK_OFS_STATUS, 32'h0000_0006, "status");
    for (int i = 0; i < 3; i++) begin
      shot <= 1'b1;
      cyc(1);
      shot <= 1'b0;
      cyc(1);
    end
    rd(`TLK_OFS_SHOTS, 32'h0000_0003, "shots");
    apb(1'b1, `TLK_OFS_CNT_CLR, `TLK_CLR_SHOTS);
    rd(`TLK_OFS_SHOTS, `TLK_ZERO32, "shots");
    counts();
    $display("test counters done");
    routed <= 1'b1;
    cyc(2);
    pin("contact", 1'b0, contact);
    apb(1'b1, `TLK_OFS_LOCK_RST, 32'h0000_0001);
    cyc(2);
    pin("contact", 1'b0, contact);
    routed <= 1'b0;
    cyc(2);
    pin("contact", 1'b0, contact);
    apb(1'b1, `TLK_OFS_LOCK_RST, 32'h0000_0001);
    cyc(2);
    pin("contact", 1'b1, contact);
    ext <= 1'b1;
    cyc(5);
    pin("contact", 1'b0, contact);
    ext <= 1'b0;
    cyc(4);
    panel <= 1'b1;
    cyc(1);
    panel <= 1'b0;
    cyc(2);
    pin("contact", 1'b1, contact);
    routed <= 1'b1;
    cyc(1);
    routed <= 1'b0;
    cyc(2);
    pin("contact", 1'b0, contact);
    dirst <= 1'b1;
    cyc(5);
    dirst <= 1'b0;
    cyc(2);
    pin("contact", 1'b1, contact);
    routed <= 1'b1;
    cyc(1);
    routed <= 1'b0;
    cyc(10);
    $display("test lockout done");
    tlk_nv_model_inst.mem[1] = 16'hFFFF;
    exp_cnt[1] = 16'hFFFF;
    rst_init();
    pin("latch", 1'b1, nv_lock_save);
    counts();
    trip(3'h2, 4'h0);
    exp_cnt[1] = 16'h0000;
    counts();
    panel <= 1'b1;
    cyc(1);
    panel <= 1'b0;
    cyc(10);
    rst_init();
    pin("latch", 1'b0, nv_lock_save);
    bat <= 1'b0;
    rst_init();
    pin("latch", 1'b1, nv_lock_save);
    counts();
    apb(1'b1, `TLK_OFS_CNT_CLR, `TLK_CLR_TRIPS);
    exp_cnt = '{default: 16'h0000};
    counts();
    $display("test power done");
    final_report();
  end
endmodule : testbench
